// file: src/host_port_pins_and_straps.v
`timescale 1ns/1ps
`default_nettype none
`include "host_port_defines.vh"

module host_port_pins_and_straps #(
   parameter IRQ_SOURCES = 8
) (
   input wire mclk,
   input wire rst,
   // host bus pins
   input wire chipSelectN,
   input wire readStrobeN,
   input wire writeStrobeN,
   input wire fifoSelect,
   input wire [6:0] hostAddr,
   input wire [31:0] hostDataIn,
   output reg [31:0] hostDataOut,
   output reg [31:0] hostDataOe,
   output reg upperPullDownEn,
   // interrupt pin
   output reg irqOut,
   output reg irqOe,
   // straps
   input wire linkRateStrap,
   output reg busWide,
   output reg defaultSpeed100,
   output reg defaultFullDuplex,
   output reg defaultAutoNeg,
   // serial prom pins
   input wire serialPromDataIn,
   output reg serialPromDataOut,
   output reg serialPromDataOe,
   output reg serialPromClock,
   output reg serialPromSelect,
   // core side: registers
   output reg [6:0] regAddr,
   output reg regRead,
   output reg regWrite,
   output reg regUpperHalf,
   output reg [31:0] regWdata,
   input wire [31:0] regRdata,
   // core side: receive data port
   input wire [31:0] rxData,
   output reg rxPop,
   // core side: transmit stream out of the fifo
   output wire txValid,
   output wire [31:0] txData,
   input wire txReady,
   output reg txFull,
   // core side: power, interrupt, crossover, prom control
   input wire sleepReq,
   output reg asleep,
   output reg readSeen,
   input wire [IRQ_SOURCES-1:0] irqSources,
   input wire [IRQ_SOURCES-1:0] irqEnable,
   input wire irqActiveHigh,
   input wire irqPushPull,
   input wire crossAuto,
   input wire crossManual,
   output reg pairAIsOutput,
   output reg pairBIsOutput,
   input wire [1:0] dataPinMode,
   input wire [1:0] clockPinMode,
   input wire gpoThree,
   input wire gpoFour,
   input wire miiTxEn,
   input wire miiTxClk,
   input wire miiRxDv,
   input wire miiRxClk,
   input wire promSelectReq,
   input wire promClockReq,
   input wire promDataOutReq,
   input wire promDataOeReq,
   output reg promDataIn
);
   // two-stage synchronisers for every pin input
   reg [2:0] strobe1_q;
   reg [2:0] strobe2_q;
   reg [7:0] addr1_q;
   reg [7:0] addr2_q;
   reg [31:0] data1_q;
   reg [31:0] data2_q;
   reg [1:0] pinMisc1_q;
   reg [1:0] pinMisc2_q;

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         strobe1_q <= 3'h7;
         strobe2_q <= 3'h7;
         addr1_q <= 8'h00;
         addr2_q <= 8'h00;
         data1_q <= 32'h00000000;
         data2_q <= 32'h00000000;
         pinMisc1_q <= 2'h0;
         pinMisc2_q <= 2'h0;
      end else begin
         strobe1_q <= {chipSelectN, readStrobeN, writeStrobeN};
         strobe2_q <= strobe1_q;
         addr1_q <= {fifoSelect, hostAddr};
         addr2_q <= addr1_q;
         data1_q <= hostDataIn;
         data2_q <= data1_q;
         pinMisc1_q <= {linkRateStrap, serialPromDataIn};
         pinMisc2_q <= pinMisc1_q;
      end
   end

   wire csActive = ~strobe2_q[2];
   wire rdLevel = csActive & ~strobe2_q[1];
   wire wrLevel = csActive & ~strobe2_q[0];
   reg rdPrev_q;
   reg wrPrev_q;
   wire rdStart = rdLevel & ~rdPrev_q;
   wire wrStart = wrLevel & ~wrPrev_q;
   wire fifoSel = addr2_q[7];
   wire [6:0] wordAddr = addr2_q[6:0];

   // strap capture a few cycles after release, once the synchronisers hold pin levels
   reg [1:0] strapWait_q;
   reg strapDone_q;

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         strapWait_q <= 2'h0;
         strapDone_q <= 1'b0;
         busWide <= 1'b0;
         defaultSpeed100 <= 1'b0;
         defaultFullDuplex <= 1'b0;
         defaultAutoNeg <= 1'b0;
         upperPullDownEn <= 1'b1;
      end else if (!strapDone_q) begin
         if (strapWait_q == `STRAP_WAIT) begin
            strapDone_q <= 1'b1;
            busWide <= pinMisc2_q[0];
            upperPullDownEn <= ~pinMisc2_q[0];
            defaultSpeed100 <= pinMisc2_q[1];
            defaultAutoNeg <= pinMisc2_q[1];
            defaultFullDuplex <= 1'b0;
         end else begin
            strapWait_q <= strapWait_q + 2'h1;
         end
      end
   end

   // region decode; fifo select forces the data ports and drops A[7:3]
   wire isRxPort = fifoSel | (wordAddr < `TX_PORT_BASE);
   wire isTxPort = fifoSel | ((wordAddr >= `TX_PORT_BASE) && (wordAddr < `CSR_BASE));
   wire [6:0] csrAddr = fifoSel ? {5'h00, wordAddr[1:0]} : wordAddr;
   wire upperHalf = ~busWide & wordAddr[0];
   wire halfLast = busWide | upperHalf;

   // transmit fifo; full blocks the write instead of overwriting
   reg txPush_q;
   reg [31:0] txWord_q;
   reg [15:0] txLow_q;
   wire txInReady;

   host_port_fifo #(
      .WIDTH(32),
      .DEPTH(`TX_FIFO_DEPTH),
      .ADDR_W(`TX_FIFO_ADDR_W)
   ) txFifo (
      .mclk(mclk),
      .rst(rst),
      .inValid(txPush_q),
      .inData(txWord_q),
      .inReady(txInReady),
      .outValid(txValid),
      .outData(txData),
      .outReady(txReady)
   );

   wire writeOk = wrStart & readSeen & ~asleep & strapDone_q;
   reg rdPending_q;
   reg rdFromRx_q;
   reg rdUpper_q;
   reg [31:0] rxHold_q;

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         rdPrev_q <= 1'b0;
         wrPrev_q <= 1'b0;
         asleep <= 1'b0;
         readSeen <= 1'b0;
         regAddr <= 7'h00;
         regRead <= 1'b0;
         regWrite <= 1'b0;
         regUpperHalf <= 1'b0;
         regWdata <= 32'h00000000;
         rxPop <= 1'b0;
         txPush_q <= 1'b0;
         txWord_q <= 32'h00000000;
         txLow_q <= 16'h0000;
         txFull <= 1'b0;
         rdPending_q <= 1'b0;
         rdFromRx_q <= 1'b0;
         rdUpper_q <= 1'b0;
         rxHold_q <= 32'h00000000;
         hostDataOut <= 32'h00000000;
         hostDataOe <= 32'h00000000;
      end else begin
         rdPrev_q <= rdLevel;
         wrPrev_q <= wrLevel;
         regRead <= 1'b0;
         regWrite <= 1'b0;
         rxPop <= 1'b0;
         txPush_q <= 1'b0;
         rdPending_q <= 1'b0;
         txFull <= ~txInReady;
         // a host write ends sleep whatever its data, and needs a fresh read after
         if (wrStart && asleep) begin
            asleep <= 1'b0;
            readSeen <= 1'b0;
         end else if (sleepReq && !asleep) begin
            asleep <= 1'b1;
            readSeen <= 1'b0;
         end else if (rdStart && !asleep && strapDone_q) begin
            readSeen <= 1'b1;
         end
         if (rdStart && !asleep && strapDone_q) begin
            rdPending_q <= 1'b1;
            rdUpper_q <= upperHalf;
            rdFromRx_q <= isRxPort;
            regUpperHalf <= upperHalf;
            if (isRxPort) begin
               // the wide word pops on its last half
               rxPop <= halfLast;
               rxHold_q <= rxData;
            end else begin
               regRead <= 1'b1;
               regAddr <= csrAddr;
            end
         end
         if (writeOk) begin
            regUpperHalf <= upperHalf;
            if (isTxPort) begin
               // narrow bus: low half first, the high half completes the word
               if (!halfLast) begin
                  txLow_q <= data2_q[15:0];
               end else if (txInReady) begin
                  txPush_q <= 1'b1;
                  txWord_q <= busWide ? data2_q : {data2_q[15:0], txLow_q};
               end
            end else begin
               regWrite <= 1'b1;
               regAddr <= csrAddr;
               regWdata <= busWide ? data2_q : {16'h0000, data2_q[15:0]};
            end
         end
         if (rdPending_q) begin
            if (rdFromRx_q) begin
               hostDataOut <= (busWide || !rdUpper_q) ? rxHold_q : {16'h0000, rxHold_q[31:16]};
            end else begin
               hostDataOut <= regRdata;
            end
         end
         // drive only while the read is held, upper lanes only when wide
         hostDataOe <= rdLevel ? (busWide ? 32'hffffffff : 32'h0000ffff) : 32'h00000000;
      end
   end

   // interrupt pin
   wire irqAny = |(irqSources & irqEnable);
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         irqOut <= 1'b0;
         irqOe <= 1'b0;
      end else begin
         // open-drain drives low when active and floats otherwise
         irqOut <= irqPushPull ? (irqAny ~^ irqActiveHigh) : 1'b0;
         irqOe <= irqPushPull | irqAny;
      end
   end

   // crossover swaps pair roles
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         pairAIsOutput <= 1'b1;
         pairBIsOutput <= 1'b0;
      end else begin
         pairAIsOutput <= ~(crossAuto | crossManual);
         pairBIsOutput <= crossAuto | crossManual;
      end
   end

   // shared prom pins; the data pin stays an input until the strap is taken
   wire dataIsProm = (dataPinMode == `PIN_MODE_PROM);
   wire clockIsProm = (clockPinMode == `PIN_MODE_PROM);
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         serialPromDataOut <= 1'b0;
         serialPromDataOe <= 1'b0;
         serialPromClock <= 1'b0;
         serialPromSelect <= 1'b0;
         promDataIn <= 1'b0;
      end else begin
         promDataIn <= pinMisc2_q[0];
         serialPromSelect <= promSelectReq & dataIsProm & clockIsProm & strapDone_q;
         case (dataPinMode)
            `PIN_MODE_PROM: begin
               serialPromDataOut <= promDataOutReq;
               serialPromDataOe <= promDataOeReq & strapDone_q;
            end
            `PIN_MODE_GPO: begin
               serialPromDataOut <= gpoThree;
               serialPromDataOe <= strapDone_q;
            end
            `PIN_MODE_MON_EN: begin
               serialPromDataOut <= miiTxEn;
               serialPromDataOe <= strapDone_q;
            end
            default: begin
               // monitored clock is resampled, so it is only a coarse view
               serialPromDataOut <= miiTxClk;
               serialPromDataOe <= strapDone_q;
            end
         endcase
         case (clockPinMode)
            `PIN_MODE_PROM: serialPromClock <= promClockReq;
            `PIN_MODE_GPO: serialPromClock <= gpoFour;
            `PIN_MODE_MON_EN: serialPromClock <= miiRxDv;
            default: serialPromClock <= miiRxClk;
         endcase
      end
   end
endmodule // host_port_pins_and_straps

`default_nettype wire

// file: src/host_port_defines.vh
// Operation
// - fifo select routes accesses to data FIFOs
// - seven bit word address picks registers or FIFOs
// - strobes count only with chip select low
// - write with chip select wakes from sleep
// - upper data pull-downs off in wide mode
// - one interrupt: sources, drive programmable; polarity only in push-pull
// - link-rate strap sets default speed and autoneg
// - bus-width strap latched at reset release
// - crossover swaps transmit and receive pair roles
// - prom data pin: prom, output three, monitor
// - prom clock pin: prom, output four, monitor
// - dedicated prom select, shared data pin
// - any write wakes, data ignored
`ifndef HOST_PORT_DEFINES_VH
`define HOST_PORT_DEFINES_VH

// word address regions on A[7:1]
`define RX_PORT_BASE 7'h00
`define TX_PORT_BASE 7'h10
`define CSR_BASE 7'h20

// pin mode codes for the shared prom pins
`define PIN_MODE_PROM 2'h0
`define PIN_MODE_GPO 2'h1
`define PIN_MODE_MON_EN 2'h2
`define PIN_MODE_MON_CLK 2'h3

// cycles after reset release before straps are sampled (two sync stages)
`define STRAP_WAIT 2'h2

`define TX_FIFO_DEPTH 8
`define TX_FIFO_ADDR_W 3

`endif

// file: src/host_port_fifo.v
`timescale 1ns/1ps
`default_nettype none

module host_port_fifo #(
   parameter WIDTH = 32,
   parameter DEPTH = 8,
   parameter ADDR_W = 3
) (
   input wire mclk,
   input wire rst,
   input wire inValid,
   input wire [WIDTH-1:0] inData,
   output wire inReady,
   output wire outValid,
   output wire [WIDTH-1:0] outData,
   input wire outReady
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [ADDR_W-1:0] wrPtr_q;
   reg [ADDR_W-1:0] rdPtr_q;
   reg [ADDR_W:0] count_q;
   wire push;
   wire pop;

   assign inReady = (count_q != DEPTH[ADDR_W:0]);
   assign outValid = (count_q != {(ADDR_W+1){1'b0}});
   assign outData = mem[rdPtr_q];
   assign push = inValid & inReady;
   assign pop = outValid & outReady;

   always @(posedge mclk) begin
      if (push) begin
         mem[wrPtr_q] <= inData;
      end
   end

   // pointers wrap by index compare so DEPTH need not be a power of two
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         wrPtr_q <= {ADDR_W{1'b0}};
         rdPtr_q <= {ADDR_W{1'b0}};
         count_q <= {(ADDR_W+1){1'b0}};
      end else begin
         if (push) begin
            wrPtr_q <= (wrPtr_q == DEPTH[ADDR_W-1:0] - 1'b1) ? {ADDR_W{1'b0}} : wrPtr_q + 1'b1;
         end
         if (pop) begin
            rdPtr_q <= (rdPtr_q == DEPTH[ADDR_W-1:0] - 1'b1) ? {ADDR_W{1'b0}} : rdPtr_q + 1'b1;
         end
         if (push && !pop) begin
            count_q <= count_q + 1'b1;
         end else if (pop && !push) begin
            count_q <= count_q - 1'b1;
         end
      end
   end
endmodule // host_port_fifo

`default_nettype wire

// file: tb/host_port_pins_and_straps_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module host_port_pins_and_straps_monitor (
   input wire logic mclk,
   input wire logic rst,
   input wire logic chipSelectN,
   input wire logic readStrobeN,
   input wire logic writeStrobeN,
   input wire logic fifoSelect,
   input wire logic [31:0] hostDataOe,
   input wire logic upperPullDownEn,
   input wire logic busWide,
   input wire logic serialPromSelect,
   input wire logic [1:0] dataPinMode,
   input wire logic [1:0] clockPinMode,
   input wire logic regRead,
   input wire logic regWrite,
   input wire logic asleep,
   input wire logic readSeen,
   input wire logic pairAIsOutput,
   input wire logic pairBIsOutput,
   input wire logic txFull
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   chk_pulldown_width: assert property (upperPullDownEn == !busWide)
      else $error("pull-down state disagrees with bus width");
   chk_narrow_upper_idle: assert property (!busWide |-> hostDataOe[31:16] == 16'h0)
      else $error("upper data driven in narrow mode");
   // three edges: two sync stages then the registered enable
   chk_read_drive: assert property (hostDataOe[0] |-> $past(chipSelectN, 3) == 1'b0 && $past(readStrobeN, 3) == 1'b0)
      else $error("data driven without a selected read");
   chk_read_cs: assert property (regRead |-> $past(chipSelectN, 3) == 1'b0 && $past(fifoSelect, 3) == 1'b0)
      else $error("register read without select or under fifo select");
   chk_write_gate: assert property (regWrite |-> $past(writeStrobeN, 3) == 1'b0 && $past(chipSelectN, 3) == 1'b0 && readSeen && !asleep)
      else $error("register write not qualified");
   chk_wake_clear: assert property ($fell(asleep) |-> ##[0:2] !readSeen)
      else $error("wake left the read flag set");
   chk_prom_select: assert property (serialPromSelect |-> $past(dataPinMode) == 2'h0 && $past(clockPinMode) == 2'h0)
      else $error("prom select while a pin is borrowed");
   chk_pair_roles: assert property (pairAIsOutput != pairBIsOutput)
      else $error("both pairs in the same role");
   cover property (regWrite);
   cover property (txFull);
   cover property ($fell(asleep));
endmodule // host_port_pins_and_straps_monitor
bind host_port_pins_and_straps host_port_pins_and_straps_monitor u_host_port_pins_and_straps_monitor (.*);
`default_nettype wire

// file: tb/host_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
   input wire logic mclk,
   output logic chipSelectN = 1'b1,
   output logic readStrobeN = 1'b1,
   output logic writeStrobeN = 1'b1,
   output logic fifoSelect = 1'b0,
   output logic [6:0] hostAddr = 7'h00,
   output logic [31:0] hostDataIn = 32'h0,
   input wire logic [31:0] hostDataOut,
   input wire logic [31:0] hostDataOe
);
   task rd(input logic [6:0] a, input logic f, input logic c, output logic [31:0] q,
           output logic [31:0] o);
      @(negedge mclk);
      hostAddr = a;
      fifoSelect = f;
      chipSelectN = !c;
      readStrobeN = 1'b0;
      repeat (6) @(negedge mclk);
      // sampled mid-cycle, well after the edge that launched the data
      q = hostDataOut;
      o = hostDataOe;
      @(negedge mclk);
      chipSelectN = 1'b1;
      readStrobeN = 1'b1;
      repeat (3) @(negedge mclk);
   endtask
   task wr(input logic [6:0] a, input logic [31:0] d, input logic f);
      @(negedge mclk);
      hostAddr = a;
      fifoSelect = f;
      hostDataIn = d;
      chipSelectN = 1'b0;
      writeStrobeN = 1'b0;
      repeat (6) @(negedge mclk);
      chipSelectN = 1'b1;
      writeStrobeN = 1'b1;
      // released bus must not keep showing the written word
      hostDataIn = ~d;
      repeat (3) @(negedge mclk);
   endtask
endmodule // host_cpu_model
`default_nettype wire

// file: tb/host_port_pins_and_straps_test.sv
`timescale 1ns/1ps
`default_nettype none
module host_port_pins_and_straps_test;
   logic mclk = 1'b0, rst = 1'b1, chipSelectN, readStrobeN, writeStrobeN, fifoSelect;
   logic [6:0] hostAddr, regAddr;
   logic [31:0] hostDataIn, hostDataOut, hostDataOe, regWdata, txData, q, o;
   logic [31:0] regRdata = 32'hc0de5a17, rxData = 32'h5eed0001;
   logic linkRateStrap = 1'b0, serialPromDataIn = 1'b0, txReady = 1'b0, sleepReq = 1'b0;
   logic upperPullDownEn, irqOut, irqOe, busWide, defaultSpeed100, defaultFullDuplex;
   logic defaultAutoNeg, serialPromDataOut, serialPromDataOe, serialPromClock, serialPromSelect;
   logic regRead, regWrite, regUpperHalf, rxPop, txValid, txFull, asleep, readSeen, promDataIn;
   logic pairAIsOutput, pairBIsOutput, irqActiveHigh = 1'b1, irqPushPull = 1'b1;
   logic [7:0] irqSources = 8'h04, irqEnable = 8'h00;
   logic crossAuto = 1'b0, crossManual = 1'b0, gpoThree = 1'b0, gpoFour = 1'b0;
   logic [1:0] dataPinMode = 2'h0, clockPinMode = 2'h0;
   logic miiTxEn = 1'b0, miiTxClk = 1'b0, miiRxDv = 1'b0, miiRxClk = 1'b0;
   logic promSelectReq = 1'b0, promClockReq = 1'b0, promDataOutReq = 1'b0, promDataOeReq = 1'b0;
   int err_count = 0, n_compared = 0, cyc = 0, rdCnt = 0, wrCnt = 0, popCnt = 0, i, m, v;
   logic [31:0] txq[$];
   host_cpu_model u_host_cpu_model (.*);
   host_port_pins_and_straps u_host_port_pins_and_straps (.*);
   always #5 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc++;
      if (regRead) rdCnt++;
      if (regWrite) wrCnt++;
      if (rxPop) popCnt++;
      if (txValid && txReady) txq.push_back(txData);
      if (cyc == 20000) begin
         err_count++;
         results();
      end
   end
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("wrong value t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task settle();
      repeat (4) @(negedge mclk);
   endtask
   task rst_dev(input logic w);
      @(negedge mclk);
      rst = 1'b1;
      serialPromDataIn = w;
      linkRateStrap = w;
      repeat (3) @(negedge mclk);
      chk({upperPullDownEn, pairAIsOutput}, 2'h3);
      rst = 1'b0;
      repeat (6) @(negedge mclk);
      chk({busWide, defaultSpeed100, defaultAutoNeg, defaultFullDuplex}, {w, w, w, 1'b0});
      chk(upperPullDownEn, !w);
   endtask
   task results();
      $display("compared %0d errors %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      rst_dev(1'b0);
      u_host_cpu_model.wr(7'h22, 32'h1, 1'b0);
      chk(wrCnt, 0);
      u_host_cpu_model.rd(7'h21, 1'b0, 1'b1, q, o);
      chk(rdCnt, 1);
      chk(regAddr, 7'h21);
      chk(regUpperHalf, 1'b1);
      chk(o, 32'h0000ffff);
      u_host_cpu_model.rd(7'h22, 1'b0, 1'b0, q, o);
      chk({rdCnt, o}, {32'h1, 32'h0});
      u_host_cpu_model.wr(7'h23, 32'h7, 1'b0);
      chk({wrCnt, 25'h0, regAddr}, {32'h1, 32'h23});
      rst_dev(1'b1);
      chk(promDataIn, 1'b1);
      u_host_cpu_model.rd(7'h24, 1'b0, 1'b1, q, o);
      chk(q, regRdata);
      chk(o, 32'hffffffff);
      u_host_cpu_model.wr(7'h26, 32'ha5a50f0f, 1'b0);
      chk({wrCnt, regWdata}, {32'h2, 32'ha5a50f0f});
      u_host_cpu_model.rd(7'h25, 1'b1, 1'b1, q, o);
      chk({popCnt, rdCnt, q}, {32'h1, 32'h2, rxData});
      // stalled consumer: ninth word must be dropped
      for (i = 0; i < 9; i++) u_host_cpu_model.wr(7'h10, i + 1, 1'b0);
      chk({txFull, wrCnt}, {1'b1, 32'h2});
      txReady = 1'b1;
      // one word leaves per cycle, so eight need more than one settle
      repeat (3) settle();
      chk(txq.size(), 8);
      for (i = 0; i < 8; i++) chk(txq[i], i + 1);
      sleepReq = 1'b1;
      settle();
      sleepReq = 1'b0;
      chk(asleep, 1'b1);
      u_host_cpu_model.wr(7'h26, 32'h0, 1'b0);
      chk({asleep, readSeen}, 2'h0);
      u_host_cpu_model.wr(7'h26, 32'h0, 1'b0);
      chk(wrCnt, 2);
      u_host_cpu_model.rd(7'h24, 1'b0, 1'b1, q, o);
      u_host_cpu_model.wr(7'h26, 32'h1, 1'b0);
      chk(wrCnt, 3);
      crossManual = 1'b1;
      settle();
      chk({pairAIsOutput, pairBIsOutput}, 2'h1);
      crossManual = 1'b0;
      settle();
      chk({pairAIsOutput, pairBIsOutput}, 2'h2);
      crossAuto = 1'b1;
      settle();
      chk({pairAIsOutput, pairBIsOutput}, 2'h1);
      promSelectReq = 1'b1;
      for (m = 1; m < 4; m++) for (v = 0; v < 2; v++) begin
         dataPinMode = 2'(m);
         clockPinMode = 2'(m);
         {gpoThree, miiTxEn, miiTxClk} = v ? (3'h4 >> (m - 1)) : ~(3'h4 >> (m - 1));
         {gpoFour, miiRxDv, miiRxClk} = v ? (3'h4 >> (m - 1)) : ~(3'h4 >> (m - 1));
         settle();
         chk(serialPromDataOut, v);
         chk(serialPromClock, v);
         chk({serialPromSelect, serialPromDataOe}, 2'h1);
      end
      dataPinMode = 2'h0;
      clockPinMode = 2'h0;
      {promClockReq, promDataOutReq, promDataOeReq} = 3'h7;
      settle();
      chk({serialPromSelect, serialPromClock, serialPromDataOut, serialPromDataOe}, 4'hf);
      for (i = 0; i < 4; i++) begin
         {irqPushPull, irqActiveHigh} = 2'(i);
         irqEnable = 8'hfb;
         settle();
         chk({irqOut, irqOe}, {irqPushPull & !irqActiveHigh, irqPushPull});
         irqEnable = 8'h04;
         settle();
         chk({irqOut, irqOe}, {irqPushPull & irqActiveHigh, 1'b1});
      end
      results();
   end
endmodule // host_port_pins_and_straps_test
`default_nettype wire
